/* File: hw/watchdog_pkg.sv */
package watchdog_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map: printed offsets are indexes, byte address is four times that
	localparam int unsigned    ADDR_W            = 20;
	localparam int unsigned    DATA_W            = 32;
	localparam int unsigned    REG_W             = 8;
	localparam logic [ADDR_W-1:0] CTRL_INDEX     = 20'h05040;
	localparam logic [ADDR_W-1:0] STATUS_INDEX   = 20'h05041;
	localparam logic [ADDR_W-1:0] CTRL_ADDR      = ADDR_W'(CTRL_INDEX * 4);
	localparam logic [ADDR_W-1:0] STATUS_ADDR    = ADDR_W'(STATUS_INDEX * 4);

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int unsigned    KEY_LSB           = 0;
	localparam int unsigned    KEY_W             = 4;
	localparam int unsigned    CLEAR_BIT         = 4;
	localparam logic [3:0]     KEY_STOP          = 4'ha;
	localparam logic [3:0]     KEY_RESET_VAL     = 4'ha;

	////////////////////////////////////////////////////////////////////////////////
	// Status register fields
	localparam int unsigned    FLAG_BIT          = 0;
	localparam int unsigned    ACTION_BIT        = 1;
	localparam logic           ACTION_NMI        = 1'b0;
	localparam logic           ACTION_RESET      = 1'b1;
	localparam logic           ACTION_RESET_VAL  = 1'b0;
	localparam logic           FLAG_RESET_VAL    = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: overflow after this many low-speed oscillator periods
	localparam int unsigned    LOW_OSC_PERIODS   = 131072;
	localparam int unsigned    TICK_DIVIDER      = 128;
	localparam int unsigned    TICKS_PER_OVF     = LOW_OSC_PERIODS / TICK_DIVIDER;

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer codes
	localparam logic [REG_W-1:0] READ_ZERO       = 8'h00;

endpackage : watchdog_pkg

/* File: hw/watchdog_timer.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Counter advances only on the 256 Hz tick (low oscillator divided by 128).
// - Uncleared for 131072 low oscillator periods, an overflow raises NMI or reset.
// - Action select 0 (default) gives NMI; 1 gives reset request.
// - Four-bit run key stops counting at 0b1010, counts otherwise; read/write.
// - Run key resets to 0b1010, so the watchdog starts stopped.
// - Stopping keeps the count; restart resumes from it.
// - Writing 1 to control bit 4 zeroes the counter; full period restarts.
// - Clear bit: writing 0 does nothing, reads always return 0.
// - NMI overflow sets read-only status flag bit 0; flag resets to 0.
// - The counter clear write also clears the status flag.
// - In HALT the watchdog keeps counting; its request ends HALT.
// - In SLEEP the tick is absent; count holds, no overflow.
// - Both registers are 8 bits; reserved bits read 0.
// - Flag is also set on overflow with reset selected; initial reset clears it.
module watchdog_timer
	import watchdog_pkg::*;
#(
	parameter int unsigned TICKS = watchdog_pkg::TICKS_PER_OVF
) (
	// Clock and reset
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [watchdog_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [watchdog_pkg::DATA_W-1:0]   pwdata,
	input  wire logic [watchdog_pkg::DATA_W/8-1:0] pstrb,
	output logic      [watchdog_pkg::DATA_W-1:0]   prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Operating tick from the oscillator block, asynchronous to pclk
	input  wire logic                              tick_256hz,
	// Requests toward the CPU core and reset logic
	output logic                                   nmi_req,
	output logic                                   reset_req
);
	import watchdog_pkg::*;

	localparam int unsigned CNT_W = $clog2(TICKS);
	localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(TICKS - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	////////////////////////////////////////////////////////////////////////////////
	// All state of the block
	typedef struct packed {
		logic             tick_s1;
		logic             tick_s2;
		logic             tick_s3;
		logic [CNT_W-1:0] count;
		logic [KEY_W-1:0] run_key;
		logic             action_sel;
		logic             ovf_flag;
		logic             nmi_q;
		logic             rst_q;
		logic [REG_W-1:0] rdata;
		logic             ready;
		logic             slverr;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic             tick_rise;
	logic             running;
	logic             setup_ph;
	logic             wr_commit;
	logic             hit_ctrl;
	logic             hit_status;
	logic             clear_req;
	logic             ovf_event;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and events
	always_comb begin
		// Edge of the synchronised tick; only stage two and three are looked at
		tick_rise  = state_reg.tick_s2 & ~state_reg.tick_s3;
		running    = (state_reg.run_key != KEY_STOP);
		setup_ph   = psel & ~penable;
		wr_commit  = psel & penable & state_reg.ready & pwrite & pstrb[0];
		hit_ctrl   = (paddr == CTRL_ADDR);
		hit_status = (paddr == STATUS_ADDR);
		clear_req  = wr_commit & hit_ctrl & pwdata[CLEAR_BIT];
		// A clear in the same cycle as the last tick wins: a fresh period starts
		ovf_event  = tick_rise & running & ~clear_req & (state_reg.count == CNT_MAX);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		state_next         = state_reg;
		state_next.tick_s1 = tick_256hz;
		state_next.tick_s2 = state_reg.tick_s1;
		state_next.tick_s3 = state_reg.tick_s2;

		// Counter: keeps its value while stopped or while no tick arrives (SLEEP)
		if (clear_req) begin
			state_next.count = CNT_ZERO;
		end else if (tick_rise && running) begin
			state_next.count = state_reg.count + CNT_W'(1);
		end

		// One request pulse per overflow, steered by the select bit now in force
		state_next.nmi_q = ovf_event & (state_reg.action_sel == ACTION_NMI);
		state_next.rst_q = ovf_event & (state_reg.action_sel == ACTION_RESET);

		// Flag: overflow sets it in either mode, the clear write drops it
		if (ovf_event) begin
			state_next.ovf_flag = 1'b1;
		end else if (clear_req) begin
			state_next.ovf_flag = 1'b0;
		end

		// Register writes; the flag itself is read-only
		if (wr_commit && hit_ctrl) begin
			state_next.run_key = pwdata[KEY_LSB +: KEY_W];
		end
		if (wr_commit && hit_status) begin
			state_next.action_sel = pwdata[ACTION_BIT];
		end

		// APB answer prepared in the setup cycle, so access needs no wait state
		state_next.ready  = setup_ph;
		state_next.slverr = setup_ph & ~(hit_ctrl | hit_status);
		state_next.rdata  = READ_ZERO;
		if (setup_ph && !pwrite && hit_ctrl) begin
			state_next.rdata[KEY_LSB +: KEY_W] = state_reg.run_key;
		end else if (setup_ph && !pwrite && hit_status) begin
			state_next.rdata[ACTION_BIT] = state_reg.action_sel;
			state_next.rdata[FLAG_BIT]   = state_reg.ovf_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg            <= '0;
			state_reg.run_key    <= KEY_RESET_VAL;
			state_reg.action_sel <= ACTION_RESET_VAL;
			state_reg.ovf_flag   <= FLAG_RESET_VAL;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign prdata    = {{(DATA_W-REG_W){1'b0}}, state_reg.rdata};
	assign pready    = state_reg.ready;
	assign pslverr   = state_reg.slverr;
	assign nmi_req   = state_reg.nmi_q;
	assign reset_req = state_reg.rst_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence ctrl_write_s;
		psel && penable && pready && pwrite && pstrb[0] && (paddr == CTRL_ADDR);
	endsequence

	sequence clear_write_s;
		ctrl_write_s ##0 pwdata[CLEAR_BIT];
	endsequence

	sequence stopped_idle_s;
		(state_reg.run_key == KEY_STOP) && !clear_req;
	endsequence

	count_tick_a: assert property (
		(state_reg.count != $past(state_reg.count)) |-> ($past(tick_rise) || $past(clear_req)))
		else $error("count moved without a tick or clear");

	ovf_nmi_a: assert property (
		(ovf_event && state_reg.action_sel == ACTION_NMI) |=> (nmi_req && !reset_req))
		else $error("NMI overflow did not raise nmi_req");

	ovf_reset_a: assert property (
		(ovf_event && state_reg.action_sel == ACTION_RESET) |=> (reset_req && !nmi_req))
		else $error("reset overflow did not raise reset_req");

	single_pulse_a: assert property (
		(nmi_req || reset_req) |=> !(nmi_req || reset_req))
		else $error("overflow request longer than one cycle");

	period_wrap_a: assert property (
		(nmi_req || reset_req) |-> (state_reg.count == CNT_ZERO && state_reg.ovf_flag))
		else $error("request without counter wrap and flag");

	stop_hold_a: assert property (
		stopped_idle_s |=> $stable(state_reg.count) ##0 !(nmi_req || reset_req))
		else $error("stopped watchdog changed count or fired");

	clear_zero_a: assert property (
		clear_write_s |=> (state_reg.count == CNT_ZERO))
		else $error("clear write did not zero the counter");

	flag_clear_a: assert property (
		(clear_write_s ##0 !ovf_event) |=> !state_reg.ovf_flag)
		else $error("clear write did not drop the flag");

	flag_set_a: assert property (
		ovf_event |=> state_reg.ovf_flag)
		else $error("overflow did not set the flag");

	clear_read_a: assert property (
		(psel && !penable && !pwrite && paddr == CTRL_ADDR) |=> (prdata[CLEAR_BIT] == 1'b0 && pready))
		else $error("clear bit read back as one");

	reserved_zero_a: assert property (
		pready |-> (prdata[DATA_W-1:CLEAR_BIT+1] == '0))
		else $error("reserved bits read nonzero");

	key_write_a: assert property (
		ctrl_write_s |=> (state_reg.run_key == $past(pwdata[KEY_LSB +: KEY_W])))
		else $error("run key not written");

	////////////////////////////////////////////////////////////////////////////////
	// Counter checks: the count is the only memory of elapsed time, so every move is guarded

	sequence tick_step_s;
		tick_rise && running && !clear_req;
	endsequence

	sequence final_tick_s;
		tick_step_s ##0 (state_reg.count == CNT_MAX);
	endsequence

	// A counted tick adds exactly one, wrapping at the end of the period
	run_count_a: assert property (
		tick_step_s |=> (state_reg.count == CNT_W'($past(state_reg.count) + 1'b1)))
		else $error("counted tick did not add one");

	// No tick and no clear: the count holds, which is what keeps SLEEP harmless
	sleep_hold_a: assert property (
		(!tick_rise && !clear_req) |=> $stable(state_reg.count))
		else $error("count moved with no tick present");

	// The last tick of a running period leads to a request unless a clear write meets it
	final_tick_a: assert property (
		final_tick_s |=> (nmi_req || reset_req))
		else $error("final tick gave no request");

	// Overflow only ever comes from the last tick of a running period
	ovf_source_a: assert property (
		ovf_event |-> (state_reg.count == CNT_MAX && running && tick_rise))
		else $error("overflow without a full period");

	// A clear that meets the final tick starts a fresh period and no request
	clear_wins_a: assert property (
		(clear_req && tick_rise && running) |=> (state_reg.count == CNT_ZERO && !(nmi_req || reset_req)))
		else $error("clear lost against the final tick");

	////////////////////////////////////////////////////////////////////////////////
	// Request checks: the CPU side must never see a request that no overflow caused

	// Every request echoes an overflow one cycle earlier
	req_source_a: assert property (
		(nmi_req || reset_req) |-> $past(ovf_event))
		else $error("request without an overflow");

	// A stopped watchdog stays quiet, whatever count it holds
	stop_quiet_a: assert property (
		!running |=> !(nmi_req || reset_req))
		else $error("stopped watchdog raised a request");

	// The two request lines are never up together
	one_line_a: assert property (
		!(nmi_req && reset_req))
		else $error("NMI and reset requested together");

	////////////////////////////////////////////////////////////////////////////////
	// Flag checks: software reads the flag after the fact, so it must not drift

	// Once set, the flag holds until a clear write
	flag_hold_a: assert property (
		(state_reg.ovf_flag && !clear_req) |=> state_reg.ovf_flag)
		else $error("flag dropped without a clear");

	// The flag rises only on an overflow
	flag_cause_a: assert property (
		$rose(state_reg.ovf_flag) |-> $past(ovf_event))
		else $error("flag rose without an overflow");

	// A status write cannot touch the read-only flag
	flag_ro_a: assert property (
		(wr_commit && hit_status && !ovf_event) |=> $stable(state_reg.ovf_flag))
		else $error("status write changed the flag");

	////////////////////////////////////////////////////////////////////////////////
	// Register bus checks

	sequence ctrl_read_s;
		setup_ph && !pwrite && hit_ctrl;
	endsequence

	sequence status_read_s;
		setup_ph && !pwrite && hit_status;
	endsequence

	// The select bit follows the written data
	action_write_a: assert property (
		(wr_commit && hit_status) |=> (state_reg.action_sel == $past(pwdata[ACTION_BIT])))
		else $error("action select not written");

	// A write with the low byte strobe off leaves both registers alone
	strobe_off_a: assert property (
		(psel && penable && pready && pwrite && !pstrb[0])
			|=> ($stable(state_reg.run_key) && $stable(state_reg.action_sel)))
		else $error("write without strobe changed a register");

	// Control read shows the run key; clear bit and reserved bits read zero
	ctrl_read_a: assert property (
		ctrl_read_s |=> (prdata[KEY_LSB +: KEY_W] == $past(state_reg.run_key) && prdata[DATA_W-1:KEY_W] == '0))
		else $error("control read data wrong");

	// Status read shows select and flag; reserved bits read zero
	status_read_a: assert property (
		status_read_s |=> (prdata[ACTION_BIT] == $past(state_reg.action_sel)
			&& prdata[FLAG_BIT] == $past(state_reg.ovf_flag) && prdata[DATA_W-1:ACTION_BIT+1] == '0))
		else $error("status read data wrong");

	// Unmapped addresses answer with an error and no data
	unmapped_err_a: assert property (
		(setup_ph && !hit_ctrl && !hit_status) |=> (pslverr && prdata == '0))
		else $error("unmapped access not refused");

	// Mapped addresses answer at once and never with an error
	mapped_ok_a: assert property (
		(setup_ph && (hit_ctrl || hit_status)) |=> (pready && !pslverr))
		else $error("mapped access answered with an error");

	// The answer stands for the access cycle only
	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held beyond the access cycle");

endmodule // watchdog_timer

/* File: tb/cpu_request_sink.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// CPU side of the watchdog: counts requests, and any request ends a halt
module cpu_request_sink (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Requests from the watchdog, halt entry from the bench
	input  wire logic nmi_req,
	input  wire logic reset_req,
	input  wire logic halt_cmd,
	output int        n_nmi,
	output int        n_rst,
	output logic      halted
);
	// Requests are one-cycle pulses, so summing levels counts pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_nmi  <= 0;
			n_rst  <= 0;
			halted <= 1'b0;
		end else begin
			n_nmi  <= n_nmi + int'(nmi_req);
			n_rst  <= n_rst + int'(reset_req);
			halted <= (halted | halt_cmd) & ~(nmi_req | reset_req);
		end
	end
endmodule // cpu_request_sink

/* File: tb/watchdog_timer_nmi_reset_test.sv */
`timescale 1ns/1ps
module watchdog_timer_nmi_reset_test;
	import watchdog_pkg::*;
	localparam int unsigned T = 4; // Short period keeps the run brief
	logic              pclk, presetn, psel, penable, pwrite, tick_256hz, halt_cmd;
	logic              pready, pslverr, nmi_req, reset_req, halted, er, strb_lo;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [3:0]        pstrb, k4;
	logic [15:0]       lfsr;
	int                n_nmi, n_rst, n_fail, tests_run, cnt, key, act, flag, e_nmi, e_rst;
	////////////////////////////////////////////////////////////////////////////////
	watchdog_timer #(.TICKS(T)) watchdog_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tick_256hz(tick_256hz), .nmi_req(nmi_req), .reset_req(reset_req));
	cpu_request_sink cpu_request_sink_inst (.pclk(pclk), .presetn(presetn), .nmi_req(nmi_req),
		.reset_req(reset_req), .halt_cmd(halt_cmd), .n_nmi(n_nmi), .n_rst(n_rst), .halted(halted));
	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high at a rising edge, then is released
	task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d);
		lfsr = lfsr_next(lfsr);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		pstrb   <= {lfsr[2:0], strb_lo};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr_ctrl(input logic [7:0] d);
		apb(1'b1, CTRL_ADDR, d);
		key = int'(d[3:0]);
		if (d[4]) begin
			cnt  = 0;
			flag = 0;
		end
	endtask
	task automatic rd_chk(input string nm, input logic [19:0] a, input logic [31:0] ex);
		apb(1'b0, a, 8'h00);
		chk(nm, ex, rd);
		chk({nm, "_err"}, 32'h0, {31'h0, er});
	endtask
	// Slow tick; the model counts only while running and compares request counts
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge pclk);
			tick_256hz <= 1'b1;
			repeat (6) @(posedge pclk);
			tick_256hz <= 1'b0;
			repeat (6) @(posedge pclk);
			if (key != 10) cnt++;
			if (cnt == T) begin
				cnt  = 0;
				flag = 1;
				if (act == 1) e_rst++;
				else e_nmi++;
			end
			chk("nmi_count", e_nmi, n_nmi);
			chk("reset_count", e_rst, n_rst);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, tick_256hz, halt_cmd} = '0;
		strb_lo = 1'b1;
		paddr  = '0;
		pwdata = '0;
		pstrb  = '0;
		lfsr   = 16'h40d0;
		{n_fail, tests_run, cnt, act, flag, e_nmi, e_rst} = '0;
		key    = 10;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl_reset", CTRL_ADDR, 32'h0000000a);
		rd_chk("status_reset", STATUS_ADDR, 32'h00000000);
		apb(1'b0, CTRL_ADDR + 20'h00008, 8'h00);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_data", 32'h0, rd);
		tick(5);
		lfsr = lfsr_next(lfsr);
		k4 = (lfsr[3:0] == KEY_STOP) ? 4'h5 : lfsr[3:0];
		wr_ctrl({4'h1, k4});
		rd_chk("ctrl_key", CTRL_ADDR, {28'h0, k4});
		// A write with the low strobe off must be ignored
		strb_lo = 1'b0;
		apb(1'b1, CTRL_ADDR, 8'h1a);
		strb_lo = 1'b1;
		rd_chk("ctrl_nostrb", CTRL_ADDR, {28'h0, k4});
		halt_cmd <= 1'b1;
		@(posedge pclk);
		halt_cmd <= 1'b0;
		@(posedge pclk);
		chk("halt_entered", 32'h1, {31'h0, halted});
		tick(T);
		chk("halted", 32'h0, {31'h0, halted});
		rd_chk("status_nmi", STATUS_ADDR, {30'h0, act[0], flag[0]});
		wr_ctrl({4'h0, k4});
		rd_chk("status_kept", STATUS_ADDR, {30'h0, act[0], flag[0]});
		wr_ctrl({4'h1, k4});
		rd_chk("status_clr", STATUS_ADDR, {30'h0, act[0], flag[0]});
		// Clears inside every period keep the requests away
		repeat (3) begin
			tick(T - 1);
			wr_ctrl({4'h1, k4});
		end
		// No tick for a while stands for SLEEP: the count must hold, then finish on wake-up
		tick(T - 1);
		repeat (200) @(posedge pclk);
		chk("sleep_nmi", e_nmi, n_nmi);
		tick(1);
		wr_ctrl({4'h1, k4});
		rd_chk("status_wake", STATUS_ADDR, {30'h0, act[0], flag[0]});
		tick(2);
		wr_ctrl(8'h0a);
		tick(3);
		wr_ctrl({4'h0, k4});
		tick(2);
		apb(1'b1, STATUS_ADDR, 8'h02);
		act = 1;
		wr_ctrl({4'h1, k4});
		tick(T);
		rd_chk("status_rst", STATUS_ADDR, {30'h0, act[0], flag[0]});
		// A second initial reset drops the flag and stops the watchdog again
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		{cnt, act, flag, e_nmi, e_rst} = '0;
		key = 10;
		rd_chk("status_reinit", STATUS_ADDR, 32'h00000000);
		rd_chk("ctrl_reinit", CTRL_ADDR, 32'h0000000a);
		tally_and_finish();
	end
endmodule // watchdog_timer_nmi_reset_test
